// ### rtl/pebi_pkg.sv
// Register map, timing counts and carrier types of the port and bus block
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
package pebi_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLKS_PER_OSC = 2;  // Clock cycles per osc period
   localparam int unsigned OSC_PER_MC   = 12;
   localparam int unsigned MC_CLKS      = CLKS_PER_OSC * OSC_PER_MC;
   localparam int unsigned HALF_CLKS    = MC_CLKS / 2;
   localparam int unsigned RST_MC       = 2;
   localparam int unsigned RST_CLKS     = RST_MC * MC_CLKS;
   localparam int unsigned PH_ALE_END   = 1;  // Strobe high, half phases 0..1
   localparam int unsigned PH_ADR_END   = 3;  // Address out, half phases 0..3
   localparam int unsigned PH_STB_BEG   = 4;  // Read strobes start

   // ---------------------------------------------------------------
   // Register indices, byte address is four times the index
   // ---------------------------------------------------------------
   localparam logic [7:0] IDX_P0   = 8'h80;
   localparam logic [7:0] IDX_AUX  = 8'h8e;
   localparam logic [7:0] IDX_P1   = 8'h90;
   localparam logic [7:0] IDX_P2   = 8'ha0;
   localparam logic [7:0] IDX_P3   = 8'hb0;
   localparam logic [7:0] IDX_FLD  = 8'hd8;
   localparam logic [7:0] IDX_FLAL = 8'hd9;
   localparam logic [7:0] IDX_FLAH = 8'hda;
   localparam logic [7:0] IDX_MODE = 8'he8;
   localparam logic [7:0] IDX_XCMD = 8'he9;
   localparam logic [7:0] IDX_XALO = 8'hea;
   localparam logic [7:0] IDX_XAHI = 8'heb;
   localparam logic [7:0] IDX_XWD  = 8'hec;
   localparam logic [7:0] IDX_XRD  = 8'hed;
   localparam logic [7:0] IDX_STAT = 8'hee;
   localparam logic [7:0] IDX_FDAT = 8'hef;
   localparam logic [7:0] IDX_PIN0 = 8'hf8;
   localparam logic [7:0] IDX_PIN1 = 8'hf9;
   localparam logic [7:0] IDX_PIN2 = 8'hfa;
   localparam logic [7:0] IDX_PIN3 = 8'hfb;
   localparam logic [7:0] IDX_PCL  = 8'hfc;
   localparam logic [7:0] IDX_PCH  = 8'hfd;
   localparam logic [7:0] IDX_VFY  = 8'hfe;

   // ---------------------------------------------------------------
   // Reset values and fields
   // ---------------------------------------------------------------
   localparam logic [7:0] PORT_RST = 8'hff;
   localparam logic [7:0] ZERO_RST = 8'h00;
   localparam logic [7:0] PD_KEEP  = 8'h0c;  // Interrupt pins stay live
   localparam int unsigned AUX_ALE_OFF = 0;
   localparam int unsigned MD_PDOWN    = 0;
   localparam int unsigned MD_EXTEX    = 1;
   localparam int unsigned MD_FLASH    = 2;
   localparam int unsigned MD_VERIFY   = 3;
   localparam int unsigned XC_GO       = 0;
   localparam int unsigned XC_WR       = 1;
   localparam int unsigned XC_P16      = 2;
   localparam int unsigned XC_CODE     = 3;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum {PEBI_CY_NORM, PEBI_CY_DATA, PEBI_CY_CODE} pebi_cyc_t;

   typedef struct packed {
      logic t2_clk;
      logic mosi;
      logic miso;
      logic sck;
      logic txd;
   } pebi_alt_out_t;

   typedef struct packed {
      logic t2;
      logic timer_two_trigger_input;
      logic sck;
      logic miso;
      logic mosi;
      logic ss;
      logic rxd;
      logic t1;
      logic t0;
      logic external_interrupt_one;
      logic external_interrupt_zero;
   } pebi_alt_in_t;

endpackage

// ### rtl/pebi_top.sv
// Port latches, pin conditioning and external memory bus sequencer
`timescale 1ns/1ps
module pebi_top #(
   parameter int unsigned AW = 10  // Avalon byte address width
) (
   input  wire logic                    REF_CLK,
   input  wire logic                    RST_N,
   input  wire logic [AW-1:0]           AVS_ADDRESS,
   input  wire logic                    AVS_READ,
   input  wire logic                    AVS_WRITE,
   input  wire logic [31:0]             AVS_WRITEDATA,
   input  wire logic [3:0]              AVS_BYTEENABLE,
   output logic      [31:0]             AVS_READDATA,
   output logic                         AVS_WAITREQUEST,
   input  wire logic [7:0]              P0_I,
   output logic      [7:0]              P0_O,
   output logic      [7:0]              P0_OE,
   output logic                         P0_PULLUP,
   input  wire logic [7:0]              P1_I,
   output logic      [7:0]              P1_O,
   output logic      [7:0]              P1_OE,
   input  wire logic [7:0]              P2_I,
   output logic      [7:0]              P2_O,
   output logic      [7:0]              P2_OE,
   input  wire logic [7:0]              P3_I,
   output logic      [7:0]              P3_O,
   output logic      [7:0]              P3_OE,
   input  wire logic                    ADDR_LATCH_I,
   output logic                         ADDR_LATCH_O,
   output logic                         ADDR_LATCH_OE,
   output logic                         CODE_READ_STROBE_N,
   input  wire logic                    RST_PIN,
   output logic                         DEV_RESET,
   input  wire pebi_pkg::pebi_alt_out_t ALT_OUT,
   output pebi_pkg::pebi_alt_in_t       ALT_IN
);

   localparam int unsigned NS = 34;
   localparam int unsigned MC = pebi_pkg::MC_CLKS;
   localparam int unsigned HC = pebi_pkg::HALF_CLKS;
   localparam int unsigned RC = pebi_pkg::RST_CLKS;
   localparam int unsigned RW = $clog2(RC + 1);
   localparam logic [NS-1:0] SYNC_RST = {1'b0, {(NS-1){1'b1}}};

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [NS-1:0] raw, s1_q, s2_q, s3_q, flt_q, flt_d;
   logic [7:0] p0_q, p1_q, p2_q, p3_q, aux_q, mode_q, xcmd_q;
   logic [7:0] xalo_q, xahi_q, xwd_q, xrd_q, fdat_q, vfy_q;
   logic [7:0] fld_q, flal_q, flah_q;
   logic [15:0] pc_q;
   logic [4:0] ph_q, ph_d, rel;
   logic [RW-1:0] rcnt_q, rcnt_d;
   pebi_pkg::pebi_cyc_t cy_q, cy_d;
   logic pend_q, pend_d, wait_q, program_pulse_input_q;
   logic [7:0] idx, rd_mux, wb;
   logic we, hit, go_ok, busy, wrap, half;
   logic pd, flash, verify, extex, wr, p16, ale_norm, ale_en;
   logic is_data, is_code, fetch, use_x, bus, p2hi;
   logic adr_win, wr_win, rw_win, rd_low, wr_low;
   logic smp_f, smp_d, program_pulse_input_fall;
   logic [7:0] p1_in, p2_in, p3_in, adr_lo, adr_hi, p1_v, p3_v;
   logic [7:0] p0_o_d, p0_oe_d, p2_o_d, p2_oe_d;
   pebi_pkg::pebi_alt_in_t alt_d;

   // ---------------------------------------------------------------
   // Pin conditioning
   // ---------------------------------------------------------------
   // Three stages, change accepted when stages two and three agree
   assign raw   = {RST_PIN, ADDR_LATCH_I, P3_I, P2_I, P1_I, P0_I};
   assign flt_d = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & flt_q);

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         s1_q  <= SYNC_RST;
         s2_q  <= SYNC_RST;
         s3_q  <= SYNC_RST;
         flt_q <= SYNC_RST;
      end else begin
         s1_q  <= raw;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         flt_q <= flt_d;
      end
   end

   // Power-down gates port one to three inputs to idle high, interrupt pins stay live
   assign pd    = mode_q[pebi_pkg::MD_PDOWN];
   assign p1_in = flt_q[15:8] | {8{pd}};
   assign p2_in = flt_q[23:16] | {8{pd}};
   assign p3_in = flt_q[31:24] | ({8{pd}} & ~pebi_pkg::PD_KEEP);

   // Alternate-function inputs handed to the peripherals
   assign alt_d = {p1_in[0], p1_in[1], p1_in[7:4], p3_in[0], p3_in[5:2]};

   // ---------------------------------------------------------------
   // Avalon slave
   // ---------------------------------------------------------------
   // One wait cycle per access; the write lands as waitrequest rises again
   assign idx = AVS_ADDRESS[AW-1:2];
   assign wb  = AVS_WRITEDATA[7:0];
   assign we  = AVS_WRITE & ~wait_q & AVS_BYTEENABLE[0];

   // Unoccupied indices read zero and swallow writes
   assign hit = (idx == pebi_pkg::IDX_P0) | (idx == pebi_pkg::IDX_AUX)
              | (idx == pebi_pkg::IDX_P1) | (idx == pebi_pkg::IDX_P2)
              | (idx == pebi_pkg::IDX_P3) | (idx >= pebi_pkg::IDX_FLD
              && idx <= pebi_pkg::IDX_FLAH) | (idx >= pebi_pkg::IDX_MODE
              && idx <= pebi_pkg::IDX_FDAT) | (idx >= pebi_pkg::IDX_PIN0
              && idx <= pebi_pkg::IDX_VFY);

   assign rd_mux =
      (idx == pebi_pkg::IDX_P0)   ? p0_q   :
      (idx == pebi_pkg::IDX_AUX)  ? aux_q  :
      (idx == pebi_pkg::IDX_P1)   ? p1_q   :
      (idx == pebi_pkg::IDX_P2)   ? p2_q   :
      (idx == pebi_pkg::IDX_P3)   ? p3_q   :
      (idx == pebi_pkg::IDX_FLD)  ? fld_q  :
      (idx == pebi_pkg::IDX_FLAL) ? flal_q :
      (idx == pebi_pkg::IDX_FLAH) ? flah_q :
      (idx == pebi_pkg::IDX_MODE) ? mode_q :
      (idx == pebi_pkg::IDX_XCMD) ? {xcmd_q[7:1], busy} :
      (idx == pebi_pkg::IDX_XALO) ? xalo_q :
      (idx == pebi_pkg::IDX_XAHI) ? xahi_q :
      (idx == pebi_pkg::IDX_XWD)  ? xwd_q  :
      (idx == pebi_pkg::IDX_XRD)  ? xrd_q  :
      (idx == pebi_pkg::IDX_STAT) ? {6'h00, DEV_RESET, busy} :
      (idx == pebi_pkg::IDX_FDAT) ? fdat_q :
      (idx == pebi_pkg::IDX_PIN0) ? flt_q[7:0] :
      (idx == pebi_pkg::IDX_PIN1) ? p1_in  :
      (idx == pebi_pkg::IDX_PIN2) ? p2_in  :
      (idx == pebi_pkg::IDX_PIN3) ? p3_in  :
      (idx == pebi_pkg::IDX_PCL)  ? pc_q[7:0]  :
      (idx == pebi_pkg::IDX_PCH)  ? pc_q[15:8] :
      (idx == pebi_pkg::IDX_VFY)  ? vfy_q  : 8'h00;

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         wait_q       <= 1'b1;
         AVS_READDATA <= 32'h0000_0000;
      end else begin
         wait_q       <= ~(wait_q & (AVS_READ | AVS_WRITE));
         AVS_READDATA <= {24'h00_0000, rd_mux};
      end
   end
   assign AVS_WAITREQUEST = wait_q;

   // Port latches and control registers
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         p0_q   <= pebi_pkg::PORT_RST;
         p1_q   <= pebi_pkg::PORT_RST;
         p2_q   <= pebi_pkg::PORT_RST;
         p3_q   <= pebi_pkg::PORT_RST;
         aux_q  <= pebi_pkg::ZERO_RST;
         mode_q <= pebi_pkg::ZERO_RST;
      end else if (we) begin
         if (idx == pebi_pkg::IDX_P0) p0_q <= wb;
         if (idx == pebi_pkg::IDX_P1) p1_q <= wb;
         if (idx == pebi_pkg::IDX_P2) p2_q <= wb;
         if (idx == pebi_pkg::IDX_P3) p3_q <= wb;
         if (idx == pebi_pkg::IDX_AUX) aux_q <= {7'h00, wb[0]};
         if (idx == pebi_pkg::IDX_MODE) mode_q <= {4'h0, wb[3:0]};
      end
   end

   // Access command registers
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         xcmd_q <= pebi_pkg::ZERO_RST;
         xalo_q <= pebi_pkg::ZERO_RST;
         xahi_q <= pebi_pkg::ZERO_RST;
         xwd_q  <= pebi_pkg::ZERO_RST;
         vfy_q  <= pebi_pkg::PORT_RST;
      end else if (we) begin
         if (go_ok) xcmd_q <= {4'h0, wb[3:1], 1'b0};
         if (idx == pebi_pkg::IDX_XALO && !busy) xalo_q <= wb;
         if (idx == pebi_pkg::IDX_XAHI && !busy) xahi_q <= wb;
         if (idx == pebi_pkg::IDX_XWD && !busy) xwd_q <= wb;
         if (idx == pebi_pkg::IDX_VFY) vfy_q <= wb;
      end
   end

   // ---------------------------------------------------------------
   // Machine-cycle sequencer
   // ---------------------------------------------------------------
   // Twelve oscillator periods per machine cycle, two halves of six
   assign wrap = ph_q == 5'(MC - 1);
   assign ph_d = wrap ? 5'h00 : ph_q + 5'h01;
   assign half = ph_q >= 5'(HC);
   assign rel  = half ? ph_q - 5'(HC) : ph_q;

   // A command waits for the next cycle boundary; busy ones are dropped
   assign busy  = pend_q | (cy_q != pebi_pkg::PEBI_CY_NORM);
   assign go_ok = (idx == pebi_pkg::IDX_XCMD) & wb[pebi_pkg::XC_GO] & ~busy;
   assign pend_d = (we & go_ok) | (pend_q & ~wrap);
   assign cy_d =
      !wrap ? cy_q :
      !pend_q ? pebi_pkg::PEBI_CY_NORM :
      xcmd_q[pebi_pkg::XC_CODE] ? pebi_pkg::PEBI_CY_CODE :
      pebi_pkg::PEBI_CY_DATA;

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ph_q   <= 5'h00;
         pend_q <= 1'b0;
         cy_q   <= pebi_pkg::PEBI_CY_NORM;
      end else begin
         ph_q   <= ph_d;
         pend_q <= pend_d;
         cy_q   <= cy_d;
      end
   end

   // Mode decode
   assign flash   = mode_q[pebi_pkg::MD_FLASH];
   assign verify  = mode_q[pebi_pkg::MD_VERIFY];
   assign extex   = mode_q[pebi_pkg::MD_EXTEX];
   assign wr      = xcmd_q[pebi_pkg::XC_WR];
   assign p16     = xcmd_q[pebi_pkg::XC_P16];
   assign is_data = cy_q == pebi_pkg::PEBI_CY_DATA;
   assign is_code = cy_q == pebi_pkg::PEBI_CY_CODE;

   // Which half reads code memory, and from which address
   assign fetch = (is_code & ~half) | (extex & ~is_data);
   assign use_x = is_data | (is_code & ~half);
   assign bus   = (fetch | is_data) & ~flash;
   assign p2hi  = ~flash & (fetch | (is_data & p16));
   assign adr_lo = use_x ? xalo_q : pc_q[7:0];
   assign adr_hi = use_x ? xahi_q : pc_q[15:8];

   // Latch strobe: both halves normally, first half only on data
   assign ale_norm = ~aux_q[pebi_pkg::AUX_ALE_OFF] | extex;
   assign ale_en = is_data ? ~half : (is_code & ~half) | ale_norm;

   // Strobe windows; outputs follow one clock later
   assign adr_win = bus & ~(is_data & half) & (rel <= 5'(pebi_pkg::PH_ADR_END));
   assign rw_win = is_data & (ph_q >= 5'(pebi_pkg::PH_STB_BEG))
                 & (ph_q <= 5'(MC - 3));
   assign wr_win = bus & is_data & wr & (ph_q >= 5'(pebi_pkg::PH_STB_BEG))
                 & (ph_q <= 5'(MC - 2));
   assign rd_low = rw_win & ~wr;
   assign wr_low = rw_win & wr;

   // Sample points sit one clock before the strobe output rises
   assign smp_f = bus & fetch & (rel == 5'(HC - 1));
   assign smp_d = bus & is_data & ~wr & (ph_q == 5'(MC - 2));

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         xrd_q  <= pebi_pkg::ZERO_RST;
         fdat_q <= pebi_pkg::ZERO_RST;
      end else begin
         if (smp_d || (smp_f && use_x)) xrd_q <= flt_q[7:0];
         if (smp_f && !use_x) fdat_q <= flt_q[7:0];
      end
   end

   // Fetch address, software write wins over the increment
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         pc_q <= 16'h0000;
      end else if (we && idx == pebi_pkg::IDX_PCL) begin
         pc_q <= {pc_q[15:8], wb};
      end else if (we && idx == pebi_pkg::IDX_PCH) begin
         pc_q <= {wb, pc_q[7:0]};
      end else if (smp_f && !use_x) begin
         pc_q <= pc_q + 16'h0001;
      end
   end

   // ---------------------------------------------------------------
   // Pin drivers
   // ---------------------------------------------------------------
   // Port zero: open drain as a port, full drive as the bus
   assign p0_o_d = adr_win ? adr_lo : wr_win ? xwd_q : 8'h00;
   assign p0_oe_d =
      flash ? (verify ? ~vfy_q : 8'h00) :
      (adr_win | wr_win) ? 8'hff :
      bus ? 8'h00 : ~p0_q;

   // Port two emits the high byte strongly, else its own latch
   assign p2_o_d  = p2hi ? adr_hi : 8'h00;
   assign p2_oe_d = flash ? 8'h00 : p2hi ? 8'hff : ~p2_q;

   // Quasi-bidirectional ports: drive lows, leave ones to pull-ups
   assign p1_v = p1_q & {ALT_OUT.sck, ALT_OUT.miso, ALT_OUT.mosi,
                         4'hf, ALT_OUT.t2_clk};
   assign p3_v = p3_q & {~rd_low, ~wr_low, 4'hf, ALT_OUT.txd, 1'b1};

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         P0_O  <= 8'h00;
         P0_OE <= 8'h00;
         P1_O  <= 8'h00;
         P1_OE <= 8'h00;
         P2_O  <= 8'h00;
         P2_OE <= 8'h00;
         P3_O  <= 8'h00;
         P3_OE <= 8'h00;
      end else begin
         P0_O  <= p0_o_d;
         P0_OE <= p0_oe_d;
         P1_O  <= 8'h00;
         P1_OE <= flash ? 8'h00 : ~p1_v;
         P2_O  <= p2_o_d;
         P2_OE <= p2_oe_d;
         P3_O  <= 8'h00;
         P3_OE <= ~p3_v;
      end
   end

   // Bus strobes; pin released in flash mode to take the pulse
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         P0_PULLUP          <= 1'b0;
         ADDR_LATCH_O       <= 1'b0;
         ADDR_LATCH_OE      <= 1'b0;
         CODE_READ_STROBE_N <= 1'b1;
         ALT_IN             <= '1;
      end else begin
         P0_PULLUP     <= bus;
         ADDR_LATCH_O  <= ~flash & ale_en
                        & (rel <= 5'(pebi_pkg::PH_ALE_END));
         ADDR_LATCH_OE <= ~flash & (ale_norm | ~(cy_q ==
                          pebi_pkg::PEBI_CY_NORM));
         CODE_READ_STROBE_N <= ~(bus & fetch
                        & (rel >= 5'(pebi_pkg::PH_STB_BEG))
                        & (rel <= 5'(HC - 2)));
         ALT_IN        <= alt_d;
      end
   end

   // ---------------------------------------------------------------
   // Flash capture and reset qualification
   // ---------------------------------------------------------------
   // Falling program pulse captures byte and address from the ports
   assign program_pulse_input_fall = flash & program_pulse_input_q & ~flt_q[32];

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         program_pulse_input_q <= 1'b1;
         fld_q  <= pebi_pkg::ZERO_RST;
         flal_q <= pebi_pkg::ZERO_RST;
         flah_q <= pebi_pkg::ZERO_RST;
      end else begin
         program_pulse_input_q <= flt_q[32];
         if (program_pulse_input_fall) begin
            fld_q  <= flt_q[7:0];
            flal_q <= flt_q[15:8];
            flah_q <= flt_q[23:16];
         end
      end
   end

   // Short glitches on the reset pin must not reset the core
   assign rcnt_d = !flt_q[33] ? '0 :
                   (rcnt_q == RW'(RC)) ? rcnt_q : rcnt_q + RW'(1);

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rcnt_q    <= '0;
         DEV_RESET <= 1'b0;
      end else begin
         rcnt_q    <= rcnt_d;
         DEV_RESET <= rcnt_d == RW'(RC);
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);

   AST_P0_OPEN_DRAIN: assert property (
      !$past(bus) && !$past(flash) |-> P0_OE == ~$past(p0_q) && P0_O == 8'h00)
      else $error("port zero not open drain as a port");

   AST_P0_PULLUP: assert property (
      P0_OE != 8'h00 && P0_O != 8'h00 |-> P0_PULLUP || $past(flash))
      else $error("port zero drives high without bus role");

   AST_WEAK_ONES: assert property (
      (P1_O & P1_OE) == 8'h00 && (P3_O & P3_OE) == 8'h00
      && (P1_OE & $past(p1_q) & 8'h1e) == 8'h00
      && (P3_OE & $past(p3_q) & 8'h3d) == 8'h00)
      else $error("quasi port drives a strong one");

   AST_P2_LATCH: assert property (
      $past(is_data) && !$past(p16) && !$past(flash) |-> P2_OE == ~$past(p2_q))
      else $error("port two left its latch on short access");

   AST_PD_GATE: assert property (
      pd && $past(pd) |-> ALT_IN.t2 && ALT_IN.rxd && ALT_IN.t0 && ALT_IN.sck)
      else $error("input not gated in power-down");

   AST_RST_QUAL: assert property (
      $rose(DEV_RESET) |-> $past(flt_q[33], 48))
      else $error("reset taken before two machine cycles");

   AST_ALE_SKIP: assert property (
      is_data && half && rel >= 5'h01 |-> !ADDR_LATCH_O)
      else $error("latch strobe not skipped on data access");

   AST_ALE_RATE: assert property (
      $rose(ADDR_LATCH_O) && !$past(flash) && ale_norm && $past(cy_q) ==
      pebi_pkg::PEBI_CY_NORM && cy_q == pebi_pkg::PEBI_CY_NORM && !pend_q
      && !half |-> ##12 (ADDR_LATCH_O || !$past(ale_norm) || $past(flash)))
      else $error("latch strobe rate wrong");

   AST_ALE_OFF: assert property (
      !$past(ale_norm) && $past(cy_q) == pebi_pkg::PEBI_CY_NORM
      |-> !ADDR_LATCH_O && !ADDR_LATCH_OE)
      else $error("latch strobe ran while disabled");

   AST_CODE_READ_STROBE_SKIP: assert property (
      is_data && $past(is_data) |-> CODE_READ_STROBE_N)
      else $error("code strobe during data access");

   AST_RD_SAMPLE: assert property (
      smp_d |-> P3_OE[7] && !P3_O[7] ##1 !P3_OE[7])
      else $error("read data not sampled inside strobe");

   AST_P0_FLOAT: assert property (
      $past(is_data) && !$past(wr) && !$past(flash) && ph_q > 5'(pebi_pkg::PH_STB_BEG)
      |-> P0_OE == 8'h00)
      else $error("port zero driven during data read");

   AST_UNMAPPED: assert property (
      AVS_READ && !AVS_WAITREQUEST && !hit |-> AVS_READDATA == 32'h0000_0000)
      else $error("unoccupied address read nonzero");

endmodule

// ### bench/pebi_mem_model.sv
// Behavioural external memory with address latch
`timescale 1ns/1ps
module pebi_mem_model (
   input  wire logic       ale,
   input  wire logic [7:0] ad,
   input  wire logic [7:0] hi,
   input  wire logic       rd_n,
   input  wire logic       cs_n,
   input  wire logic       wr_n,
   output logic            d_oe,
   output logic [7:0]      d_o,
   output logic [15:0]     xa
);
   logic [7:0]  mem [0:65535];
   logic [15:0] a;
   // Low byte caught on the strobe fall; a data strobe marks the access
   always @(negedge ale) a = {hi, ad};
   always @(negedge rd_n or negedge wr_n) xa = a;
   // Drives only while a read strobe is low, so late sampling sees the bus-role pull-up high
   assign d_oe = !rd_n || !cs_n;
   assign d_o = mem[a];
   always @(posedge wr_n) mem[a] = ad;
   // Fixed pattern that the bench recomputes on its own
   initial for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ i[15:8] ^ 8'h3c;
endmodule

// ### bench/pebi_tb_top.sv
// Self-checking bench of the port and bus block
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin mismatches++; \
   $display("mismatch %s exp %h got %h", nm, e, s); end end
module pebi_tb_top;
   logic        clk = 0;
   logic        rst_n = 0;
   logic [9:0]  adr = 0;
   logic        rd = 0;
   logic        wr = 0;
   logic [31:0] wd = 0;
   logic        rpin = 0;
   logic [7:0]  p3x = 8'hff;
   logic [7:0]  junk = 0;
   logic        cen = 0;
   int          n_ale, n_cs, mismatches, n_compared;
   logic [31:0] rdata;
   logic        wq, p0pu, ale_o, ale_oe, cs_n, dres, m_oe;
   logic [7:0]  p0o, p0e, p1o, p1e, p2o, p2e, p3o, p3e, m_d;
   logic [15:0] m_a;
   pebi_pkg::pebi_alt_in_t alt;
   // Pin levels: floating port zero pulls high in its bus role, else shows a changing pattern; others pull high
   wire [7:0] p0 = (p0o & p0e) | (~p0e & (m_oe ? m_d : (p0pu ? 8'hff : junk)));
   wire [7:0] p1 = p1o | ~p1e;
   wire [7:0] p2 = p2o | ~p2e;
   wire [7:0] p3 = (p3o | ~p3e) & p3x;
   wire       ale = ale_o | ~ale_oe;
   always #2.5 clk = ~clk;
   always @(posedge clk) junk <= ~junk ^ 8'h5a;
   // Strobe edge counters for the rate windows
   always @(posedge ale) if (cen) n_ale++;
   always @(negedge cs_n) if (cen) n_cs++;
   pebi_top dut (.REF_CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
      .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'h1), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wq),
      .P0_I(p0), .P0_O(p0o), .P0_OE(p0e), .P0_PULLUP(p0pu), .P1_I(p1), .P1_O(p1o), .P1_OE(p1e),
      .P2_I(p2), .P2_O(p2o), .P2_OE(p2e), .P3_I(p3), .P3_O(p3o), .P3_OE(p3e), .ALT_IN(alt),
      .ADDR_LATCH_I(ale), .ADDR_LATCH_O(ale_o), .ADDR_LATCH_OE(ale_oe), .ALT_OUT(5'h1f),
      .CODE_READ_STROBE_N(cs_n), .RST_PIN(rpin), .DEV_RESET(dres));
   pebi_mem_model mem (.ale(ale), .ad(p0), .hi(p2), .rd_n(p3[7]), .cs_n(cs_n), .wr_n(p3[6]),
      .d_oe(m_oe), .d_o(m_d), .xa(m_a));
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Bus cycle: request held until waitrequest is seen low at an edge
   task automatic acc(input bit w, input logic [7:0] ix, input logic [7:0] d,
                      output logic [7:0] q);
      int n;
      n = 0;
      adr <= {ix, 2'b00};
      wd <= {24'h0, d};
      wr <= w;
      rd <= !w;
      do begin
         @(posedge clk);
         n++;
      end while (wq !== 1'b0 && n < 40);
      q = rdata[7:0];
      wr <= 0;
      rd <= 0;
      @(posedge clk);
      if (n >= 40) begin
         mismatches++;
         report_and_stop();
      end
   endtask
   task automatic w8(input logic [7:0] ix, input logic [7:0] d);
      logic [7:0] q;
      acc(1, ix, d, q);
   endtask
   task automatic rchk(input logic [7:0] ix, input logic [7:0] e);
      logic [7:0] q;
      acc(0, ix, 8'h00, q);
      `CHK("reg", e, q)
   endtask
   task automatic idle();
      logic [7:0] q;
      q = 8'h01;
      for (int i = 0; i < 30 && q[0] !== 1'b0; i++)
         acc(0, pebi_pkg::IDX_STAT, 8'h00, q);
      `CHK("busy", 1'b0, q[0])
   endtask
   function automatic logic [7:0] mval(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3c;
   endfunction
   task automatic t_regs();
      rchk(pebi_pkg::IDX_P0, 8'hff);
      rchk(pebi_pkg::IDX_AUX, 8'h00);
      w8(8'h81, 8'hff);
      rchk(8'h81, 8'h00);
      w8(pebi_pkg::IDX_P1, 8'h5a);
      w8(pebi_pkg::IDX_P0, 8'h00);
      repeat (2) @(posedge clk);
      `CHK("p1", 8'h5a, p1)
      `CHK("p0oe", 8'hff, p0e)
      w8(pebi_pkg::IDX_P0, 8'hff);
      w8(pebi_pkg::IDX_P1, 8'hff);
      `CHK("p0oe", 8'h00, p0e)
   endtask
   task automatic t_xbus();
      w8(pebi_pkg::IDX_XALO, 8'h34);
      w8(pebi_pkg::IDX_XAHI, 8'h12);
      w8(pebi_pkg::IDX_XCMD, 8'h05);
      idle();
      rchk(pebi_pkg::IDX_XRD, mval(16'h1234));
      `CHK("addr", 16'h1234, m_a)
      w8(pebi_pkg::IDX_XWD, 8'ha5);
      w8(pebi_pkg::IDX_XCMD, 8'h07);
      idle();
      w8(pebi_pkg::IDX_XCMD, 8'h05);
      idle();
      rchk(pebi_pkg::IDX_XRD, 8'ha5);
      w8(pebi_pkg::IDX_P2, 8'h33);
      w8(pebi_pkg::IDX_XCMD, 8'h01);
      idle();
      `CHK("addr", 16'h3334, m_a)
      w8(pebi_pkg::IDX_XCMD, 8'h09);
      idle();
      rchk(pebi_pkg::IDX_XRD, 8'ha5);
   endtask
   // Four machine cycles of strobe edges, optionally around one data read
   task automatic win(input bit go, input int ea, input int ec);
      repeat (48) @(posedge clk);
      if (go)
         w8(pebi_pkg::IDX_XCMD, 8'h05);
      n_ale = 0;
      n_cs = 0;
      cen = 1;
      repeat (96) @(posedge clk);
      cen = 0;
      `CHK("ale", ea, n_ale)
      `CHK("cs", ec, n_cs)
   endtask
   task automatic t_ale();
      win(0, 8, 0);
      win(1, 7, 0);
      w8(pebi_pkg::IDX_AUX, 8'h01);
      win(0, 0, 0);
      win(1, 1, 0);
      w8(pebi_pkg::IDX_MODE, 8'h02);
      win(0, 8, 8);
      win(1, 7, 6);
      w8(pebi_pkg::IDX_MODE, 8'h00);
      w8(pebi_pkg::IDX_AUX, 8'h00);
   endtask
   task automatic t_pins();
      logic [7:0] q;
      w8(pebi_pkg::IDX_MODE, 8'h01);
      w8(pebi_pkg::IDX_P1, 8'h00);
      p3x <= 8'hf3;
      repeat (10) @(posedge clk);
      acc(0, pebi_pkg::IDX_PIN3, 8'h00, q);
      `CHK("pin3", 8'h00, q & 8'h0c)
      rchk(pebi_pkg::IDX_PIN1, 8'hff);
      `CHK("external_interrupt_zero", 1'b0, alt.external_interrupt_zero)
      p3x <= 8'hff;
      w8(pebi_pkg::IDX_MODE, 8'h00);
      w8(pebi_pkg::IDX_P1, 8'hff);
      rpin <= 1;
      repeat (40) @(posedge clk);
      `CHK("dres", 1'b0, dres)
      repeat (20) @(posedge clk);
      `CHK("dres", 1'b1, dres)
      rpin <= 0;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      t_regs();
      t_xbus();
      t_ale();
      t_pins();
      report_and_stop();
   end
   // A hang anywhere ends the run as a failure
   initial begin
      repeat (100000) @(posedge clk);
      mismatches++;
      report_and_stop();
   end
endmodule
